//--- rtl/spe_ctrl.sv
// Behaviour
// - Power-up clears the write latch
// - Programming starts only on byte-aligned deselect
// - Array accesses ignored during programming cycle
// - Hold edges with clock high ignored
// - Write commands need deselect right after bit eight
// - Busy discards array read, write, status write
// - Protect bits guard quarter, half, whole array
// - Unknown opcode deselects until next select
// - Opcode byte MSB first; latch, status read codes
// - Status write, array codes; bit 3 address
// - Latch must be set before each write
// - Latch change applied at deselect
// - Latch cleared by reset, commands, low protect pin
// - Status byte repeats while selected
// - Status readable when busy; protect updates later
// - Status byte: ones, protect, latch, busy
// - Busy flag high during programming cycle
// - Protect bits change only when hardware unlocked
// - Status write: one data byte, then deselect
// - Status write starts timed cycle, updates at end
// - Status write rejection conditions
// - Status write touches only the protect bits
// - Sample on rising, drive on falling, MSB first
// - Hold pause enters and leaves with clock low
// - Power-up deselected, idle, protect bits kept
`timescale 1ns/100ps
`default_nettype none
module spe_ctrl
   import spe_pkg::*;
#(
   parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
   input  wire logic              clk,              // 50 MHz clock
   input  wire logic              rst,              // Power-on reset
   input  wire logic              cs_n_pin,         // Chip select, low
   input  wire logic              sck_pin,          // Serial clock
   input  wire logic              mosi_pin,         // Serial data in
   input  wire logic              hold_n_pin,       // Hold, low
   input  wire logic              wp_n_pin,         // Write protect, low
   input  wire logic [1:0]        nv_prot_in,       // Stored protect bits
   output var  logic              miso_o,           // Serial data out
   output var  logic              miso_oe_n,        // Output enable, low
   output var  logic [1:0]        protect_level,    // Protect bits
   output var  logic              write_latch_flag, // Write latch
   output var  logic              write_busy_flag,  // Programming busy
   output var  logic              arr_rd_go,        // Array read start
   output var  logic              arr_wr_go,        // Array write start
   output var  logic [ARR_AW-1:0] arr_addr          // Array address
);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic cs_s, sck_s, mosi_s, hold_n_s, wp_n_s;
   logic cs_prev_r, sck_prev_r;

   // Reset values match the idle pins: deselected, clock low, hold off
   spe_sync #(.W(5), .RST_VAL(5'h13)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({cs_n_pin, sck_pin, mosi_pin, hold_n_pin, wp_n_pin}),
      .q   ({cs_s, sck_s, mosi_s, hold_n_s, wp_n_s})
   );

   if (PROG_CYCLES_P < 1)
   begin : g_bad_prog
      $error("spe_ctrl: PROG_CYCLES_P must be at least 1");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   spe_state_t        state_r, state_nxt;
   spe_cmd_t          cmd_r, cmd_nxt;
   logic              hold_r;
   logic [2:0]        bcnt_r;
   logic [7:0]        sh_in_r;
   logic              bnd_r;
   logic [1:0]        dcnt_r;
   logic              wp_low_r;
   logic              a8_r;
   logic [ARR_AW-1:0] addr_r;
   logic [1:0]        new_prot_r;
   logic [1:0]        prot_r;
   logic              wel_r, wel_nxt;
   logic              swr_r;
   logic              tmr_start_r, tmr_busy, tmr_done;
   logic [2:0]        ocnt_r;
   logic [6:0]        osh_r;
   logic              ostart_r;
   logic              rd_go_r, wr_go_r;

   wire sck_rise  = sck_s && !sck_prev_r;
   wire sck_fall  = !sck_s && sck_prev_r;
   wire cs_fall   = !cs_s && cs_prev_r;
   wire cs_rise   = cs_s && !cs_prev_r;
   wire selected  = (state_r != ST_IDLE) && (state_r != ST_DEAD);
   wire act_rise  = sck_rise && !hold_r && !cs_s && selected;
   wire act_fall  = sck_fall && !hold_r && !cs_s && (state_r == ST_STAT);
   wire [7:0] byte_in   = {sh_in_r[6:0], mosi_s};
   wire       byte_done = act_rise && (bcnt_r == BIT_LAST);
   wire       busy_any  = tmr_busy || tmr_start_r;
   wire [7:0] stat_byte = {ST_ONES, prot_r, wel_r, busy_any};

   // ---------------------------------------------------------------
   // Opcode decode
   // ---------------------------------------------------------------
   wire       opc_hi_ok = (byte_in[7:4] == OPC_HI_ZERO);
   wire [2:0] opc_lo    = byte_in[2:0];
   wire spe_cmd_t opc_cmd =
      !opc_hi_ok           ? CMD_NONE :
      (opc_lo == OPL_SET)  ? CMD_SET  :
      (opc_lo == OPL_CLR)  ? CMD_CLR  :
      (opc_lo == OPL_SRD)  ? CMD_SRD  :
      (opc_lo == OPL_SWR)  ? CMD_SWR  :
      (opc_lo == OPL_ARD)  ? CMD_ARD  :
      (opc_lo == OPL_AWR)  ? CMD_AWR  : CMD_NONE;

   // ---------------------------------------------------------------
   // Protect decode and execution conditions
   // ---------------------------------------------------------------
   wire prot_hit = (prot_r == PROT_ALL)
                || ((prot_r == PROT_HALF) && (addr_r >= HALF_BASE))
                || ((prot_r == PROT_QTR) && (addr_r >= QTR_BASE));
   wire hw_locked = !wp_n_s || wp_low_r;
   wire end_ok    = cs_rise && bnd_r;
   wire set_go    = end_ok && (state_r == ST_WAITCS)
                 && (cmd_r == CMD_SET);
   wire clr_go    = end_ok && (state_r == ST_WAITCS)
                 && (cmd_r == CMD_CLR);
   wire swr_go    = end_ok && (state_r == ST_DATA) && (cmd_r == CMD_SWR)
                 && (dcnt_r == 2'h1) && wel_r && !busy_any
                 && !hw_locked;
   wire awr_go    = end_ok && (state_r == ST_DATA) && (cmd_r == CMD_AWR)
                 && (dcnt_r != 2'h0) && wel_r && !busy_any
                 && !hw_locked && !prot_hit;

   // ---------------------------------------------------------------
   // Serial state machine
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cmd_nxt   = cmd_r;
      case (state_r)
         ST_OPC:
            if (byte_done)
            begin
               cmd_nxt = opc_cmd;
               case (opc_cmd)
                  CMD_SET, CMD_CLR: state_nxt = ST_WAITCS;
                  CMD_SRD:          state_nxt = ST_STAT;
                  CMD_SWR:          state_nxt = busy_any ? ST_DEAD
                                                         : ST_DATA;
                  CMD_ARD, CMD_AWR: state_nxt = busy_any ? ST_DEAD
                                                         : ST_ADDR;
                  default:          state_nxt = ST_DEAD;
               endcase
            end
         ST_ADDR:
            if (byte_done)
               state_nxt = (cmd_r == CMD_ARD) ? ST_READ : ST_DATA;
         ST_WAITCS:
            if (act_rise)
               state_nxt = ST_DEAD;
         default:
            state_nxt = state_r;
      endcase
      if (cs_rise)
         state_nxt = ST_IDLE;
      else if (cs_fall)
         state_nxt = ST_OPC;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         cmd_r   <= CMD_NONE;
      end
      else
      begin
         state_r <= state_nxt;
         cmd_r   <= cmd_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Hold and input shifting
   // ---------------------------------------------------------------
   // Hold only changes while the clock is low; other edges are ignored
   always_ff @(posedge clk)
   begin
      if (rst || !selected)
         hold_r <= 1'b0;
      else if (!sck_s)
         hold_r <= !hold_n_s;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cs_prev_r  <= 1'b1;
         sck_prev_r <= 1'b0;
      end
      else
      begin
         cs_prev_r  <= cs_s;
         sck_prev_r <= sck_s;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst || cs_fall)
      begin
         bcnt_r  <= 3'h0;
         sh_in_r <= 8'h00;
         bnd_r   <= 1'b0;
      end
      else if (act_rise)
      begin
         bcnt_r  <= bcnt_r + 3'h1;
         sh_in_r <= byte_in;
         bnd_r   <= byte_done;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst || cs_fall)
         dcnt_r <= 2'h0;
      else if (byte_done && (state_r == ST_DATA) && (dcnt_r != 2'h2))
         dcnt_r <= dcnt_r + 2'h1;
   end

   // Protect pin low at any time while selected spoils the command
   always_ff @(posedge clk)
   begin
      if (rst || cs_fall)
         wp_low_r <= !wp_n_s;
      else if (!wp_n_s && selected)
         wp_low_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         a8_r       <= 1'b0;
         addr_r     <= '0;
         new_prot_r <= PROT_NONE;
      end
      else if (byte_done)
      begin
         if (state_r == ST_OPC)
            a8_r <= byte_in[OPC_A8_BIT];
         if (state_r == ST_ADDR)
            addr_r <= {a8_r, byte_in};
         if ((state_r == ST_DATA) && (dcnt_r == 2'h0))
            new_prot_r <= byte_in[ST_PHI_BIT:ST_PLO_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Write latch, programming cycle, protect bits
   // ---------------------------------------------------------------
   spe_wtimer #(.CYCLES(PROG_CYCLES_P)) u_wtimer (
      .clk    (clk),
      .rst    (rst),
      .start  (tmr_start_r),
      .busy_o (tmr_busy),
      .done_o (tmr_done)
   );

   // A latch set at deselect wins over the end of a programming cycle
   always_comb
   begin
      wel_nxt = wel_r;
      if (!wp_n_s)
         wel_nxt = 1'b0;
      else if (set_go)
         wel_nxt = 1'b1;
      else if (clr_go || tmr_done)
         wel_nxt = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wel_r       <= 1'b0;
         tmr_start_r <= 1'b0;
         swr_r       <= 1'b0;
      end
      else
      begin
         wel_r       <= wel_nxt;
         tmr_start_r <= swr_go || awr_go;
         if (swr_go || awr_go)
            swr_r <= swr_go;
      end
   end

   // Stored bits are reloaded from the nonvolatile store at power-up
   always_ff @(posedge clk)
   begin
      if (rst)
         prot_r <= nv_prot_in;
      else if (tmr_done && swr_r && wp_n_s)
         prot_r <= new_prot_r;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_go_r <= 1'b0;
         wr_go_r <= 1'b0;
      end
      else
      begin
         rd_go_r <= byte_done && (state_r == ST_ADDR)
                 && (cmd_r == CMD_ARD);
         wr_go_r <= awr_go;
      end
   end

   // ---------------------------------------------------------------
   // Status output shifter
   // ---------------------------------------------------------------
   // The byte is resampled at each byte start so flags stay live
   always_ff @(posedge clk)
   begin
      if (rst || cs_fall)
      begin
         ocnt_r   <= 3'h0;
         osh_r    <= 7'h00;
         miso_o   <= 1'b0;
         ostart_r <= 1'b0;
      end
      else if (act_fall)
      begin
         ocnt_r   <= ocnt_r + 3'h1;
         ostart_r <= 1'b1;
         if (ocnt_r == 3'h0)
         begin
            miso_o <= stat_byte[7];
            osh_r  <= stat_byte[6:0];
         end
         else
         begin
            miso_o <= osh_r[6];
            osh_r  <= {osh_r[5:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         miso_oe_n <= 1'b1;
      else
         miso_oe_n <= !((state_r == ST_STAT) && !hold_r && !cs_s
                       && (act_fall || ostart_r));
   end

   assign protect_level    = prot_r;
   assign write_latch_flag = wel_r;
   assign write_busy_flag  = tmr_busy;
   assign arr_rd_go        = rd_go_r;
   assign arr_wr_go        = wr_go_r;
   assign arr_addr         = addr_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_latch_reset: assert property (@(posedge clk)
      rst |=> !wel_r)
      else $error("latch set after reset");
   chk_latch_wp_low: assert property (@(posedge clk) disable iff (rst)
      !wp_n_s |=> !wel_r)
      else $error("latch set while protect pin low");
   chk_start_bound: assert property (@(posedge clk) disable iff (rst)
      tmr_start_r |-> $past(bnd_r) && $past(cs_rise))
      else $error("cycle started off a byte boundary");
   chk_start_latch: assert property (@(posedge clk) disable iff (rst)
      tmr_start_r |-> $past(wel_r) && !$past(busy_any))
      else $error("cycle started without latch or while busy");
   chk_busy_follows: assert property (@(posedge clk) disable iff (rst)
      tmr_start_r |=> write_busy_flag [*2])
      else $error("busy flag not raised for programming");
   chk_busy_discard: assert property (@(posedge clk) disable iff (rst)
      byte_done && (state_r == ST_OPC) && busy_any
      && (opc_cmd inside {CMD_SWR, CMD_ARD, CMD_AWR}) && !cs_rise
      |=> state_r == ST_DEAD)
      else $error("command accepted while busy");
   chk_bad_opcode: assert property (@(posedge clk) disable iff (rst)
      byte_done && (state_r == ST_OPC) && (opc_cmd == CMD_NONE)
      && !cs_rise && !cs_fall |=> state_r == ST_DEAD ##1 miso_oe_n)
      else $error("unknown opcode not ignored");
   chk_prot_refuse: assert property (@(posedge clk) disable iff (rst)
      wr_go_r |-> !$past(prot_hit))
      else $error("write into protected range");
   chk_prot_steady: assert property (@(posedge clk) disable iff (rst)
      !tmr_done |=> $stable(prot_r))
      else $error("protect bits changed outside cycle end");
   chk_hold_float: assert property (@(posedge clk) disable iff (rst)
      hold_r |=> miso_oe_n)
      else $error("output driven during hold");
   chk_status_write_cmd_wp: assert property (@(posedge clk) disable iff (rst)
      swr_go |-> $past(wp_n_s) && !wp_low_r && (dcnt_r == 2'h1))
      else $error("status write accepted with bad conditions");

endmodule : spe_ctrl
`default_nettype wire

//--- rtl/spe_pkg.sv
`default_nettype none
package spe_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ       = 50_000_000;
   // Self-timed programming time, plain default
   localparam int PROG_TIME_NS = 100_000;
   localparam int PROG_CYCLES_RAW =
      (PROG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int PROG_CYCLES  = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;

   // ---------------------------------------------------------------
   // Instruction byte layout
   // ---------------------------------------------------------------
   localparam logic [3:0] OPC_HI_ZERO = 4'h0;
   localparam int         OPC_A8_BIT  = 3;
   localparam logic [2:0] OPL_SET     = 3'h6;
   localparam logic [2:0] OPL_CLR     = 3'h4;
   localparam logic [2:0] OPL_SRD     = 3'h5;
   localparam logic [2:0] OPL_SWR     = 3'h1;
   localparam logic [2:0] OPL_ARD     = 3'h3;
   localparam logic [2:0] OPL_AWR     = 3'h2;
   localparam logic [2:0] BIT_LAST    = 3'h7;

   // ---------------------------------------------------------------
   // Status byte layout
   // ---------------------------------------------------------------
   localparam logic [3:0] ST_ONES     = 4'hF;
   localparam int         ST_PHI_BIT  = 3;
   localparam int         ST_PLO_BIT  = 2;

   // ---------------------------------------------------------------
   // Protect decode for the 512-byte array
   // ---------------------------------------------------------------
   localparam int         ARR_AW      = 9;
   localparam logic [1:0] PROT_NONE   = 2'h0;
   localparam logic [1:0] PROT_QTR    = 2'h1;
   localparam logic [1:0] PROT_HALF   = 2'h2;
   localparam logic [1:0] PROT_ALL    = 2'h3;
   localparam logic [8:0] QTR_BASE    = 9'h180;
   localparam logic [8:0] HALF_BASE   = 9'h100;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_SET, CMD_CLR, CMD_SRD, CMD_SWR, CMD_ARD, CMD_AWR
   } spe_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_STAT, ST_READ, ST_WAITCS,
      ST_DEAD
   } spe_state_t;

endpackage : spe_pkg
`default_nettype wire

//--- rtl/spe_sync.sv
`timescale 1ns/100ps
`default_nettype none
module spe_sync
#(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input  wire logic         clk,  // System clock
   input  wire logic         rst,  // Synchronous reset
   input  wire logic [W-1:0] d,    // Asynchronous inputs
   output var  logic [W-1:0] q     // Synchronised outputs
);

   logic [W-1:0] meta_r;

   if (W < 1)
   begin : g_bad_w
      $error("spe_sync: W must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : spe_sync
`default_nettype wire

//--- rtl/spe_wtimer.sv
`timescale 1ns/100ps
`default_nettype none
module spe_wtimer
#(
   parameter int CYCLES = 5000
)
(
   input  wire logic clk,     // System clock
   input  wire logic rst,     // Synchronous reset
   input  wire logic start,   // Start one programming cycle
   output var  logic busy_o,  // Cycle running
   output var  logic done_o   // One-cycle pulse at the end
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);

   logic [CW-1:0] cnt_r;

   if (CYCLES < 1)
   begin : g_bad_cycles
      $error("spe_wtimer: CYCLES must be at least 1");
   end

   // A start during a running cycle is ignored, the cycle runs out
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r  <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= busy_o && (cnt_r == CNT_ONE);
         if (start && !busy_o)
         begin
            cnt_r  <= CNT_LOAD;
            busy_o <= 1'b1;
         end
         else if (busy_o)
         begin
            cnt_r  <= cnt_r - CNT_ONE;
            busy_o <= (cnt_r != CNT_ONE);
         end
      end
   end

   chk_timer_start: assert property (@(posedge clk) disable iff (rst)
      start && !busy_o |=> busy_o [*2])
      else $error("timer did not start");
   chk_timer_end: assert property (@(posedge clk) disable iff (rst)
      done_o |-> !busy_o && $past(busy_o))
      else $error("timer done without a running cycle");

endmodule : spe_wtimer
`default_nettype wire

//--- verif/spe_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Mode 0 SPI master, link clock 8 system clocks per bit
// ------------------------------------------------------------
module spe_master_model
(
   input  wire logic clk,  // System clock
   input  wire logic miso, // Data line from the device
   output var  logic cs_n, // Chip select, low
   output var  logic sck,  // Link clock, idle low
   output var  logic mosi  // Data to the device
);
   initial
   begin
      cs_n = 1'b1;
      sck  = 1'b0;
      mosi = 1'b0;
   end

   task automatic sel();
      @(posedge clk) cs_n <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : sel

   // Rise with clock low; released data toggles so no stale bit
   task automatic desel();
      @(posedge clk) cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (4) @(posedge clk);
   endtask : desel

   // Data set while clock low, read back late in the high phase
   task automatic bitx(input logic b, output logic r);
      @(posedge clk) mosi <= b;
      repeat (2) @(posedge clk);
      @(posedge clk) sck <= 1'b1;
      repeat (3) @(posedge clk);
      @(posedge clk) r = miso;
      sck <= 1'b0;
   endtask : bitx
endmodule : spe_master_model
`default_nettype wire

//--- verif/spi_eeprom_protect_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_protect_ctrl_tb_top;
   import spe_pkg::*;
   // Long enough for a status read to fit inside one cycle
   localparam int PROG = 400;
   logic              clk, rst, hold_n, wp_n;
   logic [1:0]        nv_prot;
   wire               cs_n, sck, mosi, miso_o, miso_oe_n, wlf, wbf;
   wire               rd_go, wr_go, miso_w;
   wire  [1:0]        prot;
   wire  [ARR_AW-1:0] addr;
   wire  [3:0]        flags = {prot, wlf, wbf};
   logic [15:0]       rx;
   int                bad_count, n_compared, n_wr, n_rd, n_oe;

   assign miso_w = miso_oe_n ? 1'bz : miso_o;

   spe_ctrl #(.PROG_CYCLES_P(PROG)) dut
   (
      .clk(clk), .rst(rst), .cs_n_pin(cs_n), .sck_pin(sck),
      .mosi_pin(mosi), .hold_n_pin(hold_n), .wp_n_pin(wp_n),
      .nv_prot_in(nv_prot), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
      .protect_level(prot), .write_latch_flag(wlf),
      .write_busy_flag(wbf), .arr_rd_go(rd_go), .arr_wr_go(wr_go),
      .arr_addr(addr)
   );

   spe_master_model m
   (
      .clk(clk), .miso(miso_w), .cs_n(cs_n), .sck(sck), .mosi(mosi)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (wr_go === 1'b1) n_wr++;
      if (rd_go === 1'b1) n_rd++;
      if (miso_oe_n === 1'b0) n_oe++;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic end_of_test();
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // One frame of nb bits taken from the top of d
   task automatic send(input logic [23:0] d, input int nb);
      logic b;
      m.sel();
      for (int i = 0; i < nb; i++)
      begin
         m.bitx(d[23-i], b);
         rx = {rx[14:0], b};
      end
      m.desel();
      repeat (10) @(posedge clk);
   endtask : send

   task automatic wait_idle();
      int n;
      for (n = 0; n < 1000 && wbf !== 1'b0; n++) @(posedge clk);
      if (n == 1000)
      begin
         chk(16'(wbf), 16'h0);
         end_of_test();
      end
      else
         repeat (2) @(posedge clk);
   endtask : wait_idle

   // Hold pause in the middle of a status read
   task automatic s_hold();
      logic b;
      m.sel();
      for (int i = 0; i < 8; i++)
         m.bitx(i == 5 || i == 7, b);
      @(posedge clk) hold_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk(16'(miso_oe_n), 16'h1);
      @(posedge clk) hold_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk(16'(miso_oe_n), 16'h0);
      m.desel();
      repeat (10) @(posedge clk);
      chk(16'(miso_oe_n), 16'h1);
   endtask : s_hold

   task automatic s_latch();
      chk(16'({miso_oe_n, flags}), 16'h18);
      send(24'h060000, 8);
      chk(16'(flags), 16'hA);
      send(24'h050000, 24);
      chk(rx, 16'hFAFA);
      chk(16'(miso_oe_n), 16'h1);
      send(24'h040000, 9);
      chk(16'(flags), 16'hA);
      send(24'h0C0000, 8);
      chk(16'(flags), 16'h8);
      send(24'h0E0000, 8);
      chk(16'(flags), 16'hA);
   endtask : s_latch

   task automatic s_swr();
      send(24'h040000, 8);
      send(24'h01F400, 16);
      chk(16'(flags), 16'h8);
      send(24'h060000, 8);
      send(24'h01F400, 17);
      chk(16'(flags), 16'hA);
      send(24'h01F400, 16);
      chk(16'(flags), 16'hB);
      send(24'h050000, 16);
      chk(16'(rx[7:0]), 16'hFB);
      wait_idle();
      chk(16'(flags), 16'h4);
      send(24'h050000, 16);
      chk(16'(rx[7:0]), 16'hF4);
   endtask : s_swr

   task automatic s_arr();
      send(24'h060000, 8);
      send(24'h0A8055, 24);
      chk(16'(n_wr), 16'h0);
      send(24'h0A7F55, 24);
      chk(16'({n_wr[3:0], flags}), 16'h17);
      chk(16'(addr), 16'h17F);
      send(24'h031000, 16);
      chk(16'(n_rd), 16'h0);
      wait_idle();
      chk(16'(flags), 16'h4);
      send(24'h0B1000, 16);
      chk(16'({n_rd[3:0], 3'h0, addr}), 16'h1110);
   endtask : s_arr

   task automatic s_bad_wp();
      int k;
      k = n_oe;
      send(24'h070500, 24);
      chk(16'(n_oe - k), 16'h0);
      @(posedge clk) wp_n <= 1'b0;
      send(24'h060000, 8);
      chk(16'(flags), 16'h4);
      send(24'h010C00, 16);
      chk(16'(flags), 16'h4);
      @(posedge clk) wp_n <= 1'b1;
   endtask : s_bad_wp

   initial
   begin
      rst     = 1'b1;
      hold_n  = 1'b1;
      wp_n    = 1'b1;
      nv_prot = 2'h2;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      s_latch();
      s_swr();
      s_arr();
      s_bad_wp();
      s_hold();
      end_of_test();
   end
endmodule : spi_eeprom_protect_ctrl_tb_top
`default_nettype wire
